/* File: logic/lpmc_pkg.sv */
// Package of constants and types for the low-power mode controller.
package lpmc_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  LPMC_ADDR_PWR_CTRL_IDX = 8'h87;
	localparam logic [11:0] LPMC_ADDR_PWR_CTRL     = {2'h0, LPMC_ADDR_PWR_CTRL_IDX, 2'h0};
	localparam logic [11:0] LPMC_ADDR_OSC          = 12'h220;
	localparam logic [11:0] LPMC_ADDR_STAT         = 12'h224;
	localparam int          LPMC_PWR_IDLE_BIT      = 0;
	localparam int          LPMC_PWR_STOP_BIT      = 1;
	localparam int          LPMC_OSC_BANDGAP_BIT   = 0;
	localparam int          LPMC_OSC_RING_SEL_BIT  = 1;
	localparam int          LPMC_OSC_RING_ACT_BIT  = 2;
	localparam logic [1:0]  LPMC_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  LPMC_RESP_SLVERR   = 2'h2;
	localparam logic [7:0]  LPMC_PORT_RESET    = 8'hff;
	localparam logic [15:0] LPMC_RESET_VECTOR  = 16'h0000;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          LPMC_XTAL_CYCLES   = 65536;
	localparam logic [16:0] LPMC_XTAL_LAST     = 17'(LPMC_XTAL_CYCLES - 1);
	localparam logic [16:0] LPMC_XTAL_ZERO     = 17'h00000;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {LPMC_EXEC_INTERNAL, LPMC_EXEC_NONPAGE, LPMC_EXEC_PAGE1, LPMC_EXEC_PAGE2} lpmc_exec_t;
	typedef enum logic [2:0] {LPMC_RUN, LPMC_IDLE, LPMC_STOP, LPMC_WARMUP, LPMC_RING} lpmc_state_t;
endpackage

/* File: logic/lpmc_xtal_counter.sv */
// Crystal start-up cycle counter.
`timescale 1ns/1ps
module lpmc_xtal_counter
	import lpmc_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic aclken,
	// Control
	input  wire logic start,
	input  wire logic halt,
	input  wire logic xtal_tick,
	// Result
	output logic      done
);
	logic [16:0] count;
	logic        busy;

	// ****************************************************************
	// Counter
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count <= LPMC_XTAL_ZERO;
			busy  <= 1'b0;
			done  <= 1'b0;
		end
		else if (aclken)
		begin
			done <= 1'b0;
			if (halt)
			begin
				busy  <= 1'b0;
				count <= LPMC_XTAL_ZERO;
			end
			else if (start)
			begin
				busy  <= 1'b1;
				count <= LPMC_XTAL_ZERO;
			end
			else if (busy && xtal_tick)
			begin
				// Counted on the crystal, not the system clock.
				if (count == LPMC_XTAL_LAST)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				count <= count + 17'h00001;
			end
		end
	end
endmodule

/* File: logic/lpmc_pins.sv */
// Pin state selection in Idle and Stop.
`timescale 1ns/1ps
module lpmc_pins
	import lpmc_pkg::*;
(
	// Mode
	input  wire logic        in_idle,
	input  wire logic        in_stop,
	input  wire lpmc_pkg::lpmc_exec_t exec_mode,
	// Latched fetch context
	input  wire logic [7:0]  next_opcode,
	input  wire logic [15:0] next_addr,
	input  wire logic [7:0]  port0_reg,
	input  wire logic [7:0]  port2_reg,
	// Selected values
	output logic [7:0]  port0_val,
	output logic [7:0]  port2_val,
	output logic        port0_od,
	output logic        port2_weak
);
	always_comb
	begin
		port0_val  = port0_reg;
		port2_val  = port2_reg;
		port0_od   = in_idle | in_stop;
		port2_weak = 1'b0;
		if (in_stop)
		begin
			// Weak pull-ups only with external program.
			port2_weak = (exec_mode != LPMC_EXEC_INTERNAL);
		end
		else if (in_idle)
		begin
			case (exec_mode)
				LPMC_EXEC_NONPAGE:
				begin
					port0_val = next_opcode;
					port2_val = next_addr[15:8];
					port0_od  = 1'b0;
				end
				LPMC_EXEC_PAGE1:
				begin
					port0_val = next_opcode;
					port2_val = next_addr[7:0];
					port0_od  = 1'b0;
				end
				LPMC_EXEC_PAGE2:
				begin
					port0_val = next_addr[7:0];
					port2_val = next_opcode;
					port0_od  = 1'b0;
				end
				default:
				begin
					port0_val = port0_reg;
					port2_val = port2_reg;
				end
			endcase
		end
	end
endmodule

/* File: logic/lpmc_top.sv */
// Low-power mode controller top with AXI4-Lite register access.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module lpmc_top
	import lpmc_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        aclken,
	// AXI4-Lite write
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Reset and wake sources
	input  wire logic        ext_reset,
	input  wire logic        wdt_reset,
	input  wire logic        brownout,
	input  wire logic        power_on_reset,
	input  wire logic        irq_external,
	input  wire logic        irq_power_fail,
	input  wire logic        irq_clocked,
	input  wire logic        xtal_tick,
	// Core fetch context
	input  wire lpmc_pkg::lpmc_exec_t exec_mode,
	input  wire logic [7:0]  next_opcode,
	input  wire logic [15:0] next_addr,
	input  wire logic [7:0]  port0_reg,
	input  wire logic [7:0]  port2_reg,
	// Core control
	output logic             core_reset,
	output logic             pc_hold,
	output logic             irq_vector_take,
	output logic             cpu_clk_en,
	output logic             periph_clk_en,
	output logic             xtal_amp_en,
	output logic             ring_osc_en,
	output logic             ring_osc_active_flag,
	output logic             wdt_reset_en,
	// Pins
	output logic             address_latch_pin,
	output logic             program_strobe_pin,
	output logic [7:0]       port0_out,
	output logic [7:0]       port2_out,
	output logic             port0_open_drain,
	output logic             port2_weak_pullup
);
	lpmc_state_t state;
	lpmc_state_t next_state;
	logic        idle_bit;
	logic        stop_bit;
	logic        bandgap_in_stop_select;
	logic        ring_osc_select;
	logic        any_reset;
	logic        stop_wake;
	logic        xtal_done;
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic        w_lane0;
	logic        do_write;
	logic [7:0]  p0_sel;
	logic [7:0]  p2_sel;
	logic        p0_od_sel;
	logic        p2_weak_sel;

	// ****************************************************************
	// Reset and wake qualification
	// ****************************************************************
	// The watchdog is masked in Stop, and supply dips are too unless bandgap_in_stop_select keeps the band gap running to judge them.
	always_comb
	begin
		any_reset = ext_reset | power_on_reset;
		if (state != LPMC_STOP)
		begin
			any_reset = any_reset | wdt_reset | brownout;
		end
		else
		begin
			any_reset = any_reset | (brownout & bandgap_in_stop_select);
		end
		stop_wake = irq_external | (irq_power_fail & bandgap_in_stop_select);
	end

	// ****************************************************************
	// Mode state machine
	// ****************************************************************
	always_comb
	begin
		next_state = state;
		case (state)
			LPMC_RUN:
			begin
				if (stop_bit)
				begin
					next_state = LPMC_STOP;
				end
				else if (idle_bit)
				begin
					next_state = LPMC_IDLE;
				end
			end
			LPMC_IDLE:
			begin
				if (irq_external | irq_power_fail | irq_clocked)
				begin
					next_state = LPMC_RUN;
				end
			end
			LPMC_STOP:
			begin
				if (stop_wake)
				begin
					next_state = ring_osc_select ? LPMC_RING : LPMC_WARMUP;
				end
			end
			LPMC_WARMUP:
			begin
				if (xtal_done)
				begin
					next_state = LPMC_RUN;
				end
			end
			LPMC_RING:
			begin
				if (stop_bit)
				begin
					next_state = LPMC_STOP;
				end
				else if (xtal_done)
				begin
					next_state = LPMC_RUN;
				end
			end
			default:
			begin
				next_state = LPMC_RUN;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= LPMC_RUN;
		end
		else if (aclken)
		begin
			if (any_reset)
			begin
				state <= LPMC_RUN;
			end
			else
			begin
				state <= next_state;
			end
		end
	end

	lpmc_xtal_counter u_xtal
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.aclken    (aclken),
		.start     (state == LPMC_STOP && stop_wake && !any_reset),
		.halt      (any_reset || next_state == LPMC_STOP),
		.xtal_tick (xtal_tick),
		.done      (xtal_done)
	);

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	// Address and data are held separately so either may arrive first.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h00000000;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= LPMC_RESP_OKAY;
		end
		else if (aclken)
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held  <= 1'b1;
				w_data  <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == LPMC_ADDR_PWR_CTRL || aw_addr == LPMC_ADDR_OSC) ?
					LPMC_RESP_OKAY : LPMC_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= LPMC_RESP_OKAY;
		end
		else if (aclken)
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= LPMC_RESP_OKAY;
				s_axi_rdata  <= 32'h00000000;
				case (s_axi_araddr)
					LPMC_ADDR_PWR_CTRL:
					begin
						s_axi_rdata[LPMC_PWR_IDLE_BIT] <= idle_bit;
						s_axi_rdata[LPMC_PWR_STOP_BIT] <= stop_bit;
					end
					LPMC_ADDR_OSC:
					begin
						s_axi_rdata[LPMC_OSC_BANDGAP_BIT]  <= bandgap_in_stop_select;
						s_axi_rdata[LPMC_OSC_RING_SEL_BIT] <= ring_osc_select;
						s_axi_rdata[LPMC_OSC_RING_ACT_BIT] <= ring_osc_active_flag;
					end
					LPMC_ADDR_STAT:
					begin
						s_axi_rdata[2:0] <= state;
					end
					default:
					begin
						s_axi_rresp <= LPMC_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Power control and oscillator bits
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			idle_bit <= 1'b0;
			stop_bit <= 1'b0;
		end
		else if (aclken)
		begin
			if (any_reset)
			begin
				idle_bit <= 1'b0;
				stop_bit <= 1'b0;
			end
			else if (do_write && aw_addr == LPMC_ADDR_PWR_CTRL && w_lane0)
			begin
				idle_bit <= w_data[LPMC_PWR_IDLE_BIT];
				stop_bit <= w_data[LPMC_PWR_STOP_BIT];
			end
			else
			begin
				if (state == LPMC_IDLE && next_state == LPMC_RUN)
				begin
					idle_bit <= 1'b0;
				end
				if (state == LPMC_STOP && next_state != LPMC_STOP)
				begin
					idle_bit <= 1'b0;
					stop_bit <= 1'b0;
				end
			end
		end
	end

	// Ring select survives every reset except power-on.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ring_osc_select        <= 1'b0;
			bandgap_in_stop_select <= 1'b0;
		end
		else if (aclken)
		begin
			if (power_on_reset)
			begin
				ring_osc_select        <= 1'b0;
				bandgap_in_stop_select <= 1'b0;
			end
			else if (do_write && aw_addr == LPMC_ADDR_OSC && w_lane0)
			begin
				ring_osc_select        <= w_data[LPMC_OSC_RING_SEL_BIT];
				bandgap_in_stop_select <= w_data[LPMC_OSC_BANDGAP_BIT];
			end
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	lpmc_pins u_pins
	(
		.in_idle     (next_state == LPMC_IDLE && !any_reset),
		.in_stop     (next_state == LPMC_STOP && !any_reset),
		.exec_mode   (exec_mode),
		.next_opcode (next_opcode),
		.next_addr   (next_addr),
		.port0_reg   (port0_reg),
		.port2_reg   (port2_reg),
		.port0_val   (p0_sel),
		.port2_val   (p2_sel),
		.port0_od    (p0_od_sel),
		.port2_weak  (p2_weak_sel)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_reset           <= 1'b1;
			pc_hold              <= 1'b0;
			irq_vector_take      <= 1'b0;
			cpu_clk_en           <= 1'b1;
			periph_clk_en        <= 1'b1;
			xtal_amp_en          <= 1'b1;
			ring_osc_en          <= 1'b0;
			ring_osc_active_flag <= 1'b0;
			wdt_reset_en         <= 1'b1;
			address_latch_pin    <= 1'b1;
			program_strobe_pin   <= 1'b1;
			port0_out            <= LPMC_PORT_RESET;
			port2_out            <= LPMC_PORT_RESET;
			port0_open_drain     <= 1'b0;
			port2_weak_pullup    <= 1'b0;
		end
		else if (aclken)
		begin
			core_reset           <= any_reset;
			pc_hold              <= !any_reset && (next_state == LPMC_IDLE || next_state == LPMC_STOP
				|| next_state == LPMC_WARMUP);
			irq_vector_take      <= !any_reset && state != next_state
				&& (state == LPMC_IDLE || state == LPMC_STOP);
			cpu_clk_en           <= any_reset || (next_state != LPMC_STOP && next_state != LPMC_WARMUP);
			periph_clk_en        <= any_reset || next_state != LPMC_STOP;
			xtal_amp_en          <= any_reset || next_state != LPMC_STOP;
			ring_osc_en          <= !any_reset && next_state == LPMC_RING;
			ring_osc_active_flag <= !any_reset && next_state == LPMC_RING;
			wdt_reset_en         <= next_state != LPMC_STOP;
			address_latch_pin    <= 1'b1;
			program_strobe_pin   <= 1'b1;
			port0_out            <= p0_sel;
			port2_out            <= p2_sel;
			port0_open_drain     <= p0_od_sel;
			port2_weak_pullup    <= p2_weak_sel;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_stop_wake;
		aclken && state == LPMC_STOP && stop_wake && !any_reset;
	endsequence
	property p_stop_priority;
		@(posedge aclk) disable iff (!aresetn)
		aclken && state == LPMC_RUN && stop_bit && idle_bit && !any_reset |=> state == LPMC_STOP;
	endproperty
	a_stop_priority: assert property (p_stop_priority) else $error("stop did not win over idle");
	property p_stop_clocks;
		@(posedge aclk) disable iff (!aresetn)
		aclken && state == LPMC_STOP && !stop_wake && !any_reset |=> !periph_clk_en && !xtal_amp_en;
	endproperty
	a_stop_clocks: assert property (p_stop_clocks) else $error("clocks ran in stop");
	property p_no_clocked_wake;
		@(posedge aclk) disable iff (!aresetn)
		aclken && state == LPMC_STOP && !irq_external && !irq_power_fail && !any_reset |=> state == LPMC_STOP;
	endproperty
	a_no_clocked_wake: assert property (p_no_clocked_wake) else $error("clocked source woke stop");
	property p_pf_bgs;
		@(posedge aclk) disable iff (!aresetn)
		aclken && state == LPMC_STOP && irq_power_fail && !irq_external && !bandgap_in_stop_select
			&& !ext_reset && !power_on_reset |=> state == LPMC_STOP;
	endproperty
	a_pf_bgs: assert property (p_pf_bgs) else $error("power fail woke without band gap");
	property p_wdt_stop;
		@(posedge aclk) disable iff (!aresetn)
		aclken && state == LPMC_STOP && wdt_reset && !ext_reset && !power_on_reset && !brownout
			|=> !core_reset;
	endproperty
	a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog reset in stop");
	property p_ext_reset;
		@(posedge aclk) disable iff (!aresetn)
		aclken && ext_reset |=> state == LPMC_RUN && core_reset && !idle_bit && !stop_bit;
	endproperty
	a_ext_reset: assert property (p_ext_reset) else $error("external reset did not end mode");
	property p_ring_wake;
		@(posedge aclk) disable iff (!aresetn)
		s_stop_wake ##0 ring_osc_select |=> ring_osc_active_flag && !pc_hold;
	endproperty
	a_ring_wake: assert property (p_ring_wake) else $error("ring wake did not run at once");
	property p_warmup_hold;
		@(posedge aclk) disable iff (!aresetn)
		s_stop_wake ##0 !ring_osc_select ##1 (aclken && !any_reset && !xtal_done) |=> pc_hold;
	endproperty
	a_warmup_hold: assert property (p_warmup_hold) else $error("execution ran during warm-up");
	property p_idle_wake;
		@(posedge aclk) disable iff (!aresetn)
		aclken && state == LPMC_IDLE && irq_clocked && !any_reset |=> !idle_bit && irq_vector_take;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");
endmodule

/* File: verif/lpmc_src_model.sv */
// Crystal source model that ticks only while its amplifier is enabled.
`timescale 1ns/1ps
module lpmc_src_model
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Crystal
	input  wire logic xtal_amp_en,
	output logic      xtal_tick
);
	// ****************************************************************
	// Crystal
	// ****************************************************************
	// A stopped amplifier gives no ticks, so a stalled warm-up shows as a hang.
	always_ff @(posedge aclk)
	begin
		xtal_tick <= aresetn & xtal_amp_en;
	end
endmodule

/* File: verif/low_power_mode_controller_tb_top.sv */
// Register-level testbench of the low-power mode controller.
`timescale 1ns/1ps
module low_power_mode_controller_tb_top;
	import lpmc_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic aclk, aresetn, aclken, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_reset, wdt_reset, brownout, power_on_reset;
	logic irq_external, irq_power_fail, irq_clocked, xtal_tick, core_reset, pc_hold, irq_vector_take, cpu_clk_en;
	logic periph_clk_en, xtal_amp_en, ring_osc_en, ring_osc_active_flag, wdt_reset_en, address_latch_pin;
	logic program_strobe_pin, port0_open_drain, port2_weak_pullup;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rrv;
	logic [7:0]  next_opcode, port0_reg, port2_reg, port0_out, port2_out;
	logic [15:0] next_addr;
	lpmc_exec_t  exec_mode;
	int          err_total;
	int          compares;
	int          vt_cnt = 0;
	int          n;
	lpmc_top u_dut (.*);
	lpmc_src_model u_src (.*);
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic report_and_stop();
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic chk1(input logic s, input logic e);
		chk({7'h0, s}, {7'h0, e});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do
		begin
			@(posedge aclk);
			k++;
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && k < 99);
		s_axi_bready <= 1'b0;
		chk({6'h0, s_axi_bresp}, {6'h0, r});
		if (k >= 99)
		begin
			err_total++;
			report_and_stop();
		end
	endtask
	task automatic rd(input logic [11:0] a);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do
		begin
			@(posedge aclk);
			k++;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && k < 99);
		s_axi_rready <= 1'b0;
		rdv = s_axi_rdata;
		rrv = s_axi_rresp;
		if (k >= 99)
		begin
			err_total++;
			report_and_stop();
		end
	endtask
	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		if (irq_vector_take === 1'b1)
			vt_cnt <= vt_cnt + 1;
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ext_reset, wdt_reset, brownout, power_on_reset, irq_external, irq_power_fail, irq_clocked} = '0;
		{aclken, s_axi_wstrb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {1'b1, 4'hf, 56'h0};
		{next_opcode, next_addr, port0_reg, port2_reg} = 40'ha5_1234_3c_c3;
		exec_mode = LPMC_EXEC_NONPAGE;
		err_total = 0;
		compares = 0;
		cyc(2);
		aresetn <= 1'b1;
		rd(LPMC_ADDR_PWR_CTRL);
		chk(rdv[7:0], 8'h00);
		rd(12'h300);
		chk({6'h0, rrv}, {6'h0, LPMC_RESP_SLVERR});
		wr(12'h300, 8'h01, LPMC_RESP_SLVERR);
		wr(LPMC_ADDR_PWR_CTRL, 8'h01, LPMC_RESP_OKAY);
		cyc(3);
		chk({pc_hold, cpu_clk_en, periph_clk_en, address_latch_pin, program_strobe_pin}, 8'h1f);
		chk1(wdt_reset_en, 1'b1);
		chk(port0_out, next_opcode);
		chk(port2_out, next_addr[15:8]);
		exec_mode <= LPMC_EXEC_PAGE2;
		cyc(3);
		chk(port0_out, next_addr[7:0]);
		chk(port2_out, next_opcode);
		aclken <= 1'b0;
		irq_clocked <= 1'b1;
		cyc(3);
		chk1(pc_hold, 1'b1);
		aclken <= 1'b1;
		cyc(3);
		irq_clocked <= 1'b0;
		cyc(2);
		chk(vt_cnt[7:0], 8'h01);
		chk1(pc_hold, 1'b0);
		rd(LPMC_ADDR_PWR_CTRL);
		chk(rdv[7:0], 8'h00);
		exec_mode <= LPMC_EXEC_INTERNAL;
		wr(LPMC_ADDR_PWR_CTRL, 8'h03, LPMC_RESP_OKAY);
		cyc(3);
		rd(LPMC_ADDR_STAT);
		chk(rdv[7:0], 8'h02);
		chk({cpu_clk_en, periph_clk_en, xtal_amp_en, ring_osc_en, port0_open_drain}, 8'h01);
		chk1(wdt_reset_en, 1'b0);
		{irq_clocked, irq_power_fail, wdt_reset, brownout} <= 4'hf;
		exec_mode <= LPMC_EXEC_NONPAGE;
		cyc(4);
		chk1(core_reset, 1'b0);
		chk1(port2_weak_pullup, 1'b1);
		chk(port2_out, port2_reg);
		{irq_clocked, irq_power_fail, wdt_reset, brownout} <= 4'h0;
		rd(LPMC_ADDR_STAT);
		chk(rdv[7:0], 8'h02);
		irq_external <= 1'b1;
		cyc(2);
		irq_external <= 1'b0;
		rd(LPMC_ADDR_STAT);
		chk(rdv[7:0], 8'h03);
		n = 0;
		while (pc_hold === 1'b1 && n < 70000)
		begin
			cyc(1);
			n++;
		end
		chk1(n > 65000 && n < 70000, 1'b1);
		if (n >= 70000)
			report_and_stop();
		chk(vt_cnt[7:0], 8'h02);
		wr(LPMC_ADDR_OSC, 8'h03, LPMC_RESP_OKAY);
		wr(LPMC_ADDR_PWR_CTRL, 8'h02, LPMC_RESP_OKAY);
		cyc(3);
		irq_power_fail <= 1'b1;
		cyc(2);
		irq_power_fail <= 1'b0;
		rd(LPMC_ADDR_OSC);
		chk(rdv[7:0], 8'h07);
		chk({pc_hold, ring_osc_en, ring_osc_active_flag}, 8'h03);
		wr(LPMC_ADDR_PWR_CTRL, 8'h02, LPMC_RESP_OKAY);
		cyc(3);
		chk({ring_osc_en, xtal_amp_en}, 8'h00);
		brownout <= 1'b1;
		cyc(3);
		chk1(core_reset, 1'b1);
		brownout <= 1'b0;
		cyc(3);
		rd(LPMC_ADDR_PWR_CTRL);
		chk(rdv[7:0], 8'h00);
		rd(LPMC_ADDR_OSC);
		chk({6'h0, rdv[1:0]}, 8'h03);
		wr(LPMC_ADDR_PWR_CTRL, 8'h02, LPMC_RESP_OKAY);
		cyc(3);
		ext_reset <= 1'b1;
		cyc(3);
		chk1(core_reset, 1'b1);
		{ext_reset, power_on_reset} <= 2'h1;
		cyc(3);
		power_on_reset <= 1'b0;
		cyc(3);
		wr(LPMC_ADDR_PWR_CTRL, 8'h01, LPMC_RESP_OKAY);
		wdt_reset <= 1'b1;
		cyc(3);
		chk1(core_reset, 1'b1);
		wdt_reset <= 1'b0;
		cyc(2);
		chk1(pc_hold, 1'b0);
		rd(LPMC_ADDR_OSC);
		chk({6'h0, rdv[1:0]}, 8'h00);
		report_and_stop();
	end
endmodule
